// *** src/tt_pkg.sv ***
/*
 * Shared constants, types and decode helpers for the tone transceiver
 * host port. Assumes one 10 MHz clock and a host that strobes each access.
 */
package tt_pkg;
  // Register addresses on the select line
  localparam logic REG_DATA = 1'b0;
  localparam logic REG_CTL  = 1'b1;
  // Reset value of every host register
  localparam logic [3:0] REG_RESET = 4'h0;
  // Primary control fields
  localparam int PC_TONE  = 0;
  localparam int PC_MODE  = 1;
  localparam int PC_IRQ   = 2;
  localparam int PC_STEER = 3;
  // Secondary control fields
  localparam int SC_BURST  = 0;
  localparam int SC_TEST   = 1;
  localparam int SC_SINGLE = 2;
  localparam int SC_COLROW = 3;
  // Timing: one tick per millisecond
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int BURST_MS      = 51;
  localparam int CP_BURST_MS   = 102;
  localparam int GTP_MS        = 40;
  localparam int GTA_MS        = 40;
  // Host access kinds, coded as {select, read}
  typedef enum logic [1:0] {
    TT_OP_WR_TX  = 2'b00,
    TT_OP_RD_RX  = 2'b01,
    TT_OP_WR_CTL = 2'b10,
    TT_OP_RD_ST  = 2'b11
  } tt_op_t;
  // Burst sequencer states
  typedef enum logic [1:0] {
    TT_IDLE  = 2'b00,
    TT_BURST = 2'b01,
    TT_PAUSE = 2'b10
  } tt_burst_st_t;
  // Decode of the select and read/write lines
  function automatic tt_op_t bus_op(input logic rs, input logic rw);
    return tt_op_t'({rs, rw});
  endfunction
endpackage

// *** src/tt_burst_if.sv ***
/*
 * Link between the register bank and the burst sequencer.
 * Assumes both ends share the one system clock.
 */
`timescale 1ns/100ps
interface tt_burst_if;
  logic start;
  logic long_mode;
  logic burst_on;
  logic ready;
  modport timer (input start, input long_mode, output burst_on, output ready);
  modport ctl   (output start, output long_mode, input burst_on, input ready);
endinterface

// *** src/tt_guard.sv ***
/*
 * Guard-time filter producing delayed steering and a latch pulse.
 * Assumes a one-cycle millisecond tick and a synchronous tone-seen input.
 */
`timescale 1ns/100ps
module tt_guard #(
  parameter int GTP_TICKS = tt_pkg::GTP_MS,
  parameter int GTA_TICKS = tt_pkg::GTA_MS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Timing and tone detect
  input  wire logic tick,
  input  wire logic tone_seen,
  // Delayed steering, low while tone valid
  output logic      steer_n_q,
  output logic      valid_pulse
);
  localparam logic [7:0] GTP_END = 8'(GTP_TICKS - 1);
  localparam logic [7:0] GTA_END = 8'(GTA_TICKS - 1);
  if (GTP_TICKS < 1 || GTP_TICKS > 256 || GTA_TICKS < 1 || GTA_TICKS > 256)
  begin : g_chk
    $error("guard times must be 1 to 256 ticks");
  end
  logic [7:0] cnt_q;
  logic       diff;
  logic       flip;
  // Mismatch between tone and steering state; any return resets the wait
  assign diff = (tone_seen == steer_n_q);
  assign flip = diff && tick && (cnt_q == (steer_n_q ? GTP_END : GTA_END));
  assign valid_pulse = flip && steer_n_q;
  // Guard counter, restarts on every glitch so dropouts are absorbed
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_q <= 8'h00;
    else if (!diff || flip)
      cnt_q <= 8'h00;
    else if (tick)
      cnt_q <= cnt_q + 8'h01;
  end
  // Steering changes only after the full guard time
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      steer_n_q <= 1'b1;
    else if (flip)
      steer_n_q <= !steer_n_q;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_guard_wait;
    $changed(steer_n_q) |-> $past(tick) && $past(diff);
  endproperty
  a_guard_wait: assert property (p_guard_wait) else $error("steering moved early");
endmodule

// *** src/tt_burst.sv ***
/*
 * Timed burst and pause sequencer for the transmitter.
 * Assumes a one-cycle millisecond tick from the host port divider.
 */
`timescale 1ns/100ps
module tt_burst #(
  parameter int BURST_TICKS    = tt_pkg::BURST_MS,
  parameter int CP_BURST_TICKS = tt_pkg::CP_BURST_MS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Millisecond enable
  input  wire logic tick,
  // Control link
  tt_burst_if.timer bi
);
  if (BURST_TICKS < 1 || BURST_TICKS > 255 || CP_BURST_TICKS < 1 || CP_BURST_TICKS > 255)
  begin : g_chk
    $error("burst lengths must be 1 to 255 ticks");
  end
  tt_pkg::tt_burst_st_t st_q;
  logic [7:0]           cnt_q;
  logic [7:0]           len_q;
  logic                 last;
  assign last = tick && (cnt_q == len_q - 8'h01);
  assign bi.burst_on = (st_q == tt_pkg::TT_BURST);
  assign bi.ready = last && (st_q == tt_pkg::TT_PAUSE);
  // Burst then equal pause; a new write restarts the sequence
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q  <= tt_pkg::TT_IDLE;
      cnt_q <= 8'h00;
      len_q <= 8'(BURST_TICKS);
    end
    else if (bi.start)
    begin
      st_q  <= tt_pkg::TT_BURST;
      cnt_q <= 8'h00;
      len_q <= bi.long_mode ? 8'(CP_BURST_TICKS) : 8'(BURST_TICKS);
    end
    else if (tick)
    begin
      cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
      case (st_q)
        tt_pkg::TT_BURST: if (last) st_q <= tt_pkg::TT_PAUSE;
        tt_pkg::TT_PAUSE: if (last) st_q <= tt_pkg::TT_IDLE;
        default:          st_q <= tt_pkg::TT_IDLE;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_burst_len;
    (st_q != tt_pkg::TT_IDLE) |-> (cnt_q < len_q);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst count overran");
  property p_cp_len;
    bi.start && bi.long_mode |=> len_q == 8'(CP_BURST_TICKS);
  endproperty
  a_cp_len: assert property (p_cp_len) else $error("long burst not doubled");
endmodule

// *** src/tt_host_port.sv ***
/*
 * Host register port of the tone transceiver: register decode, control
 * registers, receive latch, status flags and the request pin.
 * Assumes host inputs synchronous to clk and one strobe per access.
 */
`timescale 1ns/100ps
module tt_host_port #(
  parameter int TICK_CYCLES = tt_pkg::TICK_CYCLES,
  parameter int GTP_TICKS   = tt_pkg::GTP_MS,
  parameter int GTA_TICKS   = tt_pkg::GTA_MS
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Host bus
  input  wire logic       chip_select_n,
  input  wire logic       register_select_line,
  input  wire logic       read_not_write,
  input  wire logic       bus_strobe,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  // Receiver front end
  input  wire logic       early_detect_output,
  input  wire logic [3:0] detected_code,
  input  wire logic       cp_tone_in,
  // Open-drain request pin
  output logic            request_or_tone_pin_o,
  output logic            request_or_tone_pin_oe,
  // Transmitter controls
  output logic      [3:0] tone_code,
  output logic            tone_output_enable,
  output logic            single_tone,
  output logic            column_tones,
  output logic            bandpass_enable,
  // Receiver state
  output logic      [3:0] decoded_digit_bits,
  output logic            steer_guard_n
);

  //**********************************************************
  // Parameter checks and local widths
  //**********************************************************

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_END = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2)
  begin : g_chk
    $error("tick divider needs at least 2 cycles");
  end

  //**********************************************************
  // Host access decode
  //**********************************************************

  tt_pkg::tt_op_t op;
  logic           acc;
  logic           wr_tx;
  logic           rd_rx;
  logic           wr_ctl;
  logic           rd_st;

  // One access per strobe while selected
  assign acc    = bus_strobe && !chip_select_n;
  assign op     = tt_pkg::bus_op(register_select_line, read_not_write);
  assign wr_tx  = acc && (op == tt_pkg::TT_OP_WR_TX);
  assign rd_rx  = acc && (op == tt_pkg::TT_OP_RD_RX);
  assign wr_ctl = acc && (op == tt_pkg::TT_OP_WR_CTL);
  assign rd_st  = acc && (op == tt_pkg::TT_OP_RD_ST);

  //**********************************************************
  // Millisecond tick divider
  //**********************************************************

  logic [TW-1:0] tick_cnt_q;
  logic          tick;

  assign tick = (tick_cnt_q == TICK_END);

  // Free running so burst and guard times share one time base
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + TW'(1);
  end

  //**********************************************************
  // Control registers
  //**********************************************************

  logic [3:0] primary_control_q;
  logic [3:0] secondary_control_q;
  logic       steer_next_q;
  logic       cp_mode;
  logic       irq_en;
  logic       burst_mode;
  logic       test_mode;

  assign cp_mode    = primary_control_q[tt_pkg::PC_MODE];
  assign irq_en     = primary_control_q[tt_pkg::PC_IRQ];
  assign burst_mode = !secondary_control_q[tt_pkg::SC_BURST];
  assign test_mode  = secondary_control_q[tt_pkg::SC_TEST];

  // Control writes land in primary unless the steer flag is armed
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      primary_control_q   <= tt_pkg::REG_RESET;
      secondary_control_q <= tt_pkg::REG_RESET;
    end
    else if (wr_ctl && steer_next_q)
      secondary_control_q <= data_in;
    else if (wr_ctl)
      primary_control_q <= data_in;
  end

  // Steer flag covers exactly one following control write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      steer_next_q <= 1'b0;
    else if (wr_ctl)
      steer_next_q <= !steer_next_q && data_in[tt_pkg::PC_STEER];
  end

  //**********************************************************
  // Transmit code and burst control
  //**********************************************************

  logic [3:0] tone_code_out_q;
  tt_burst_if bi ();

  // Write-only: nothing on the bus ever reads this back
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tone_code_out_q <= tt_pkg::REG_RESET;
    else if (wr_tx)
      tone_code_out_q <= data_in;
  end

  assign bi.start     = wr_tx && burst_mode;
  assign bi.long_mode = cp_mode;

  tt_burst u_burst (
    .clk   (clk),
    .reset (reset),
    .tick  (tick),
    .bi    (bi)
  );

  assign tone_code          = tone_code_out_q;
  assign single_tone        = secondary_control_q[tt_pkg::SC_SINGLE];
  assign column_tones       = secondary_control_q[tt_pkg::SC_COLROW];
  assign bandpass_enable    = cp_mode;
  // Tone gate works in both burst and free mode
  assign tone_output_enable = primary_control_q[tt_pkg::PC_TONE]
                              && (!burst_mode || bi.burst_on);

  //**********************************************************
  // Receiver latch
  //**********************************************************

  logic       steer_n_q;
  logic       valid_pulse;
  logic       latch_ok;
  logic [3:0] decoded_digit_q;

  tt_guard #(
    .GTP_TICKS (GTP_TICKS),
    .GTA_TICKS (GTA_TICKS)
  ) u_guard (
    .clk         (clk),
    .reset       (reset),
    .tick        (tick),
    .tone_seen   (early_detect_output && !cp_mode),
    .steer_n_q   (steer_n_q),
    .valid_pulse (valid_pulse)
  );

  // Decoding is suspended in call progress mode
  assign latch_ok = valid_pulse && !cp_mode;

  // Only a guard-validated tone reaches the register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      decoded_digit_q <= tt_pkg::REG_RESET;
    else if (latch_ok)
      decoded_digit_q <= detected_code;
  end

  assign decoded_digit_bits = decoded_digit_q;
  assign steer_guard_n      = steer_n_q;

  //**********************************************************
  // Status flags
  //**********************************************************

  logic rx_full_q;
  logic tx_ready_q;
  logic irq_flag;

  // New data wins over a same-cycle status read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rx_full_q <= 1'b0;
    else if (latch_ok)
      rx_full_q <= 1'b1;
    else if (rd_st)
      rx_full_q <= 1'b0;
  end

  // Ready after the pause; free mode holds it clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tx_ready_q <= 1'b0;
    else if (!burst_mode)
      tx_ready_q <= 1'b0;
    else if (bi.ready)
      tx_ready_q <= 1'b1;
    else if (rd_st)
      tx_ready_q <= 1'b0;
  end

  assign irq_flag = rx_full_q || tx_ready_q;

  //**********************************************************
  // Read data path
  //**********************************************************

  logic [3:0] data_out_q;
  logic       data_oe_q;

  // Read data is captured at the strobe and driven the next cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      data_out_q <= 4'h0;
    else if (rd_rx)
      data_out_q <= decoded_digit_q;
    else if (rd_st)
      data_out_q <= {steer_n_q, rx_full_q, tx_ready_q, irq_flag};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      data_oe_q <= 1'b0;
    else
      data_oe_q <= rd_rx || rd_st;
  end

  assign data_out = data_out_q;
  assign data_oe  = data_oe_q;

  //**********************************************************
  // Request pin
  //**********************************************************

  logic pin_low;
  logic pin_low_q;

  // Pin shows tone square wave, test steering, or the request
  always_comb
  begin
    if (cp_mode)
      pin_low = irq_en && !cp_tone_in;
    else if (test_mode)
      pin_low = !steer_n_q;
    else
      pin_low = irq_en && irq_flag;
  end

  // Registered so the pin never glitches on decode hazards
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pin_low_q <= 1'b0;
    else
      pin_low_q <= pin_low;
  end

  // Open drain: only ever pulls low, the pull-up releases it
  assign request_or_tone_pin_o  = 1'b0;
  assign request_or_tone_pin_oe = pin_low_q;

  //**********************************************************
  // Assertions
  //**********************************************************

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_stat_read;
    rd_st && !latch_ok;
  endsequence

  sequence s_steer_write;
    wr_ctl && steer_next_q;
  endsequence

  property p_status_clear;
    s_stat_read |=> !rx_full_q;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("rx flag survived read");

  property p_latch;
    latch_ok |=> rx_full_q && decoded_digit_q == $past(detected_code);
  endproperty
  a_latch: assert property (p_latch) else $error("valid tone not latched");

  property p_cp_freeze;
    cp_mode && !wr_ctl |=> $stable(decoded_digit_q);
  endproperty
  a_cp_freeze: assert property (p_cp_freeze) else $error("digit changed in cp mode");

  property p_steer_once;
    s_steer_write |=> secondary_control_q == $past(data_in) && !steer_next_q
                      && $stable(primary_control_q);
  endproperty
  a_steer_once: assert property (p_steer_once) else $error("steered write misrouted");

  property p_tx_write;
    wr_tx |=> tone_code == $past(data_in);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx code not stored");

  property p_req_pin;
    !cp_mode && !test_mode && irq_en && irq_flag && !wr_ctl
      |=> request_or_tone_pin_oe;
  endproperty
  a_req_pin: assert property (p_req_pin) else $error("request pin not pulled");

  property p_status_or;
    rd_st |=> data_out[0] == (data_out[1] || data_out[2]) && data_oe;
  endproperty
  a_status_or: assert property (p_status_or) else $error("status b0 wrong");

  property p_free_clear;
    !burst_mode |=> !tx_ready_q;
  endproperty
  a_free_clear: assert property (p_free_clear) else $error("ready set in free mode");

  property p_cp_pin;
    cp_mode && irq_en && !wr_ctl |=> request_or_tone_pin_oe == !$past(cp_tone_in);
  endproperty
  a_cp_pin: assert property (p_cp_pin) else $error("cp tone not on pin");

  property p_tone_gate;
    !primary_control_q[tt_pkg::PC_TONE] |-> !tone_output_enable;
  endproperty
  a_tone_gate: assert property (p_tone_gate) else $error("tone on while disabled");

endmodule

// *** test/tt_host_model.sv ***
/*
 * Host bus master model: one strobed register access per call.
 * Assumes the port samples the bus on the rising edge of clk.
 */
`timescale 1ns/100ps
module tt_host_model (
  // Clock
  input  wire logic       clk,
  // Bus towards the port
  output logic            chip_select_n,
  output logic            register_select_line,
  output logic            read_not_write,
  output logic            bus_strobe,
  output logic      [3:0] data_in,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe
);
  // Idle bus until the first access
  initial
  begin
    chip_select_n = 1'b1;
    register_select_line = 1'b0;
    read_not_write = 1'b1;
    bus_strobe = 1'b0;
    data_in = 4'h0;
  end

  // One access; read data taken only while the port enables it
  task automatic acc(input logic rs, input logic rnw, input logic [3:0] wd,
                     output logic [3:0] rd);
    @(negedge clk);
    chip_select_n = 1'b0;
    register_select_line = rs;
    read_not_write = rnw;
    data_in = wd;
    bus_strobe = 1'b1;
    @(negedge clk);
    rd = (data_oe === 1'b1) ? data_out : 4'hX;
    bus_strobe = 1'b0;
    chip_select_n = 1'b1;
    // Released data lines must not keep the last value
    data_in = ~wd;
  endtask

  // Power-up sequence: status read, control clears around one steer
  task automatic soft_reset(output logic [3:0] rd);
    logic [3:0] junk;
    acc(1'b1, 1'b1, 4'h0, junk);
    acc(1'b1, 1'b0, 4'h0, junk);
    acc(1'b1, 1'b0, 4'h0, junk);
    acc(1'b1, 1'b0, 4'h8, junk);
    acc(1'b1, 1'b0, 4'h0, junk);
    acc(1'b1, 1'b1, 4'h0, rd);
  endtask
endmodule

// *** test/tt_host_port_tb.sv ***
/*
 * Self-checking bench for the tone transceiver host port.
 * Assumes tt_host_model drives the bus; short tick and guard counts.
 */
`timescale 1ns/100ps
module tt_host_port_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cs_n, rs, rnw, strobe, oe, early, cp_tone, pin_oe;
  logic        tone_en, single, col, bpf, steer_n, pin_o;
  logic [3:0]  din, dout, code, txc, digit, rd, v;
  logic [3:0]  e_digit = 4'h0;
  logic [31:0] seed = 32'h23C6;
  bit          e_full, e_ready;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;

  // 10 MHz clock
  always #50 clk = ~clk;

  tt_host_model host (.clk(clk), .chip_select_n(cs_n), .register_select_line(rs),
    .read_not_write(rnw), .bus_strobe(strobe), .data_in(din), .data_out(dout),
    .data_oe(oe));

  // Short tick and guard counts keep bursts to a few hundred cycles
  tt_host_port #(.TICK_CYCLES(4), .GTP_TICKS(2), .GTA_TICKS(2)) uut (.clk(clk),
    .reset(reset), .chip_select_n(cs_n), .register_select_line(rs),
    .read_not_write(rnw), .bus_strobe(strobe), .data_in(din), .data_out(dout),
    .data_oe(oe), .early_detect_output(early), .detected_code(code),
    .cp_tone_in(cp_tone), .request_or_tone_pin_o(pin_o),
    .request_or_tone_pin_oe(pin_oe), .tone_code(txc), .tone_output_enable(tone_en),
    .single_tone(single), .column_tones(col), .bandpass_enable(bpf),
    .decoded_digit_bits(digit), .steer_guard_n(steer_n));

  // Hang guard, well above the planned run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Status read; the model drops both flags just as the read does
  task automatic st_chk(input logic [3:0] mask);
    host.acc(1'b1, 1'b1, 4'h0, rd);
    chk("status", {1'b1, e_full, e_ready, e_full | e_ready} & mask, rd & mask);
    e_full = 1'b0;
    e_ready = 1'b0;
  endtask

  // Tone pair, optionally broken by a dropout shorter than the guard
  task automatic tone(input logic [3:0] c, input int len, input int gap);
    @(negedge clk);
    early = 1'b1;
    code = c;
    repeat (len) @(negedge clk);
    if (gap > 0)
    begin
      early = 1'b0;
      repeat (gap) @(negedge clk);
      chk("steer", 4'h0, {3'h0, steer_n});
      early = 1'b1;
      repeat (len) @(negedge clk);
    end
    early = 1'b0;
    code = ~c;
  endtask

  // Main sequence
  initial
  begin
    cp_tone = 1'b1;
    early = 1'b0;
    code = 4'h0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    host.soft_reset(rd);
    chk("status", 4'h8, rd);
    chk("pin", 4'h0, {3'h0, pin_oe});
    chk("pin_o", 4'h0, {3'h0, pin_o});
    host.acc(1'b0, 1'b1, 4'h0, rd);
    chk("rxread", 4'h0, rd);
    // Steered write lands in secondary, the next one in primary
    host.acc(1'b1, 1'b0, 4'hC, rd);
    host.acc(1'b1, 1'b0, 4'hD, rd);
    chk("sec", 4'h3, {2'h0, col, single});
    host.acc(1'b1, 1'b0, 4'h5, rd);
    chk("sec", 4'h3, {2'h0, col, single});
    chk("pri", 4'h1, {2'h0, bpf, tone_en});
    repeat (4)
    begin
      seed = lfsr(seed);
      host.acc(1'b0, 1'b0, seed[3:0], rd);
      chk("txcode", seed[3:0], txc);
    end
    // Too short to validate
    tone(4'h9, 2, 0);
    repeat (20) @(negedge clk);
    chk("digit", e_digit, digit);
    st_chk(4'hF);
    // Valid tones with a dropout, interrupt enabled
    repeat (3)
    begin
      seed = lfsr(seed);
      v = seed[3:0];
      tone(v, 12, 2);
      e_digit = v;
      e_full = 1'b1;
      chk("pin", 4'h1, {3'h0, pin_oe});
      repeat (20) @(negedge clk);
      chk("digit", v, digit);
      chk("steer", 4'h1, {3'h0, steer_n});
      st_chk(4'hF);
      @(negedge clk);
      chk("pin", 4'h0, {3'h0, pin_oe});
      host.acc(1'b0, 1'b1, 4'h0, rd);
      chk("rxread", v, rd);
    end
    // Call progress: comparator on the pin, receiver frozen
    host.acc(1'b1, 1'b0, 4'h6, rd);
    chk("pri", 4'h2, {2'h0, bpf, tone_en});
    cp_tone = 1'b0;
    repeat (3) @(negedge clk);
    chk("pin", 4'h1, {3'h0, pin_oe});
    cp_tone = 1'b1;
    repeat (3) @(negedge clk);
    chk("pin", 4'h0, {3'h0, pin_oe});
    tone(~e_digit, 12, 0);
    chk("steer", 4'h1, {3'h0, steer_n});
    repeat (20) @(negedge clk);
    chk("digit", e_digit, digit);
    st_chk(4'hF);
    // Burst in call progress mode lasts twice as long
    host.acc(1'b1, 1'b0, 4'hA, rd);
    host.acc(1'b1, 1'b0, 4'h0, rd);
    host.acc(1'b0, 1'b0, 4'h5, rd);
    repeat (500) @(negedge clk);
    st_chk(4'h7);
    repeat (400) @(negedge clk);
    e_ready = 1'b1;
    st_chk(4'h7);
    // Burst in tone mode raises the request when ready
    host.acc(1'b1, 1'b0, 4'h5, rd);
    host.acc(1'b0, 1'b0, 4'h3, rd);
    chk("tone", 4'h1, {3'h0, tone_en});
    repeat (380) @(negedge clk);
    chk("tone", 4'h0, {3'h0, tone_en});
    chk("pin", 4'h0, {3'h0, pin_oe});
    n = 0;
    while (pin_oe !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk("pin", 4'h1, {3'h0, pin_oe});
    e_ready = 1'b1;
    st_chk(4'hF);
    // Test mode: pin follows delayed steering, free mode
    host.acc(1'b1, 1'b0, 4'h8, rd);
    host.acc(1'b1, 1'b0, 4'h3, rd);
    seed = lfsr(seed);
    v = seed[3:0];
    tone(v, 12, 0);
    e_digit = v;
    e_full = 1'b1;
    chk("pin", 4'h1, {3'h0, pin_oe});
    chk("pin_o", 4'h0, {3'h0, pin_o});
    repeat (20) @(negedge clk);
    chk("pin", 4'h0, {3'h0, pin_oe});
    chk("digit", v, digit);
    st_chk(4'hF);
    final_report();
  end
endmodule
